// >>> verilog/vc3_mon_cfg.svh
/*
 * Constants of the VC-3 path monitor: register offsets, field positions,
 * reset values, overhead byte positions and persistence counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef VC3_MON_CFG_SVH
`define VC3_MON_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_EXP_TRACE   8'h04
`define OFS_DEG_CFG     8'h08
`define OFS_STATUS      8'h0c
`define OFS_ACC_TRACE   8'h10
`define OFS_NEAR_COUNT  8'h14
`define OFS_FAR_COUNT   8'h18
`define OFS_SECOND      8'h1c

// ==========================================================
// Control fields and reset values
`define CTRL_MON_BIT    0
`define CTRL_SSFREP_BIT 1
`define CTRL_RDIREP_BIT 2
`define CTRL_TRACE_MISMATCH_DISABLE_BIT 3
`define CTRL_RESET      4'h1
`define EXP_TRACE_RESET 8'h00
`define DEG_THR_RESET   16'h0001
`define DEG_WIN_RESET   4'h2

// ==========================================================
// Overhead byte positions in the frame, counted from the trace byte
`define POS_TRACE       10'h000
`define POS_PARITY      10'h055
`define POS_LABEL       10'h0aa
`define POS_STATUS      10'h0ff
`define POS_LAST        10'h2fc

// ==========================================================
// Labels, bit positions and persistence counts
`define LABEL_AIS       8'hff
`define LABEL_UNEQ      8'h00
`define RDI_BIT         3
`define REI_MAX         4'h8
`define PERSIST_FRAMES  3'h5
`define TRACE_FRAMES    3'h3

`endif

// >>> verilog/vc3_mon_pkg.sv
/*
 * Types of the VC-3 path monitor.
 * Assumes vc3_mon_cfg.svh is compiled alongside.
 */
`default_nettype none

package vc3_mon_pkg;

    // Sampled path pins
    typedef struct packed {
        logic       clk;
        logic       fs;
        logic       ssf;
        logic       eq;
        logic [7:0] data;
    } pin_t;

    // Correlated fault causes
    typedef struct packed {
        logic uneq;
        logic tim;
        logic deg;
        logic rdi;
        logic ssf;
    } cause_t;

    // Persistence filter state
    typedef struct packed {
        logic       defect;
        logic [2:0] cnt;
    } persist_t;

endpackage

`default_nettype wire

// >>> verilog/vc3_path_monitor.sv
/*
 * Non-intrusive VC-3 path monitor with an APB register slave.
 * Assumes byte-wide path data and frame start change away from the
 * rising path clock edge, and a one-cycle oneSecond pulse on mclk.
 */
// What this block does
// - Recover trace byte, present accepted trace value
// - Even parity per bit over previous frame
// - Parity mismatch counts one near errored block
// - Far error code 1..8 means one block
// - Far block count feeds far-end monitoring
// - Status bit five is remote defect
// - Status bits six to eight ignored
// - Label byte drives unequipped and AIS detection
// - Defects suppressed by server fail or AIS
// - Trace mismatch detection can be disabled
// - AIS raised after five all-ones labels
// - AIS cleared after five other labels
// - Trail fail on fail, AIS, unequipped, mismatch
// - Trail degraded follows degraded defect
// - Unequipped cause when unequipped and monitored
// - Mismatch cause unless unequipped, when monitored
// - Degraded cause unless mismatch, when monitored
// - Remote cause gated by defects, mode, enable
// - Server cause on fail or AIS, enabled
// - Defect seconds from trail fail, equipment defect, remote defect
// - Near and far block counts summed separately
`timescale 1ns/1ps
`include "vc3_mon_cfg.svh"
`default_nettype none

module vc3_path_monitor #(
    parameter int CNT_W = 16
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               pathClk,
    input  wire logic [7:0]         pathData,
    input  wire logic               pathFrameStart,
    input  wire logic               incomingServerFail,
    input  wire logic               equipmentDefectIn,
    input  wire logic               oneSecond,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    trailFailAction,
    output logic                    trailDegradedAction,
    output vc3_mon_pkg::cause_t     faultCause,
    output logic [7:0]              acceptedTraceId,
    output logic [CNT_W-1:0]        nearBlockErrorCount,
    output logic [CNT_W-1:0]        farBlockErrorCount,
    output logic                    nearDefectSecond,
    output logic                    farDefectSecond,
    output logic                    perfValid
);
    import vc3_mon_pkg::*;

    // ==========================================================
    // Helpers
    function automatic persist_t persistStep(persist_t s, logic cond, logic [2:0] n);
        persist_t r;
        r = s;
        if (cond == s.defect) begin
            r.cnt = 3'h0;
        end else if (s.cnt + 3'h1 == n) begin
            r.defect = cond;
            r.cnt    = 3'h0;
        end else begin
            r.cnt = s.cnt + 3'h1;
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] satAdd(logic [CNT_W-1:0] a, logic b);
        return (&a) ? a : a + {{(CNT_W-1){1'b0}}, b};
    endfunction

    // ==========================================================
    // Pin synchronisers
    pin_t       syncA_r;
    pin_t       syncB_r;
    logic       clkPrev_r;
    logic       pathEdge;
    logic [9:0] byteIdx_r;
    logic [9:0] curIdx;

    always_ff @(posedge mclk) begin
        syncA_r   <= '{pathClk, pathFrameStart, incomingServerFail, equipmentDefectIn, pathData};
        syncB_r   <= syncA_r;
        clkPrev_r <= syncB_r.clk;
    end

    assign pathEdge = syncB_r.clk & ~clkPrev_r;
    assign curIdx   = syncB_r.fs ? `POS_TRACE :
                      (byteIdx_r == `POS_LAST) ? byteIdx_r : byteIdx_r + 10'h001;

    always_ff @(posedge mclk) begin
        if (srst) begin
            byteIdx_r <= `POS_LAST;
        end else if (pathEdge) begin
            byteIdx_r <= curIdx;
        end
    end

    // ==========================================================
    // Control registers
    logic [3:0]  ctrl_r;
    logic [7:0]  expTrace_r;
    logic [15:0] degrade_threshold_r;
    logic [3:0]  degWin_r;
    logic        wrEn;
    logic        monitored;
    logic        suppress;

    assign wrEn      = psel & penable & pready & pwrite;
    assign monitored = ctrl_r[`CTRL_MON_BIT];

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r     <= `CTRL_RESET;
            expTrace_r <= `EXP_TRACE_RESET;
            degrade_threshold_r   <= `DEG_THR_RESET;
            degWin_r   <= `DEG_WIN_RESET;
        end else if (wrEn) begin
            if (paddr == `OFS_CTRL) begin
                ctrl_r <= pwdata[3:0];
            end else if (paddr == `OFS_EXP_TRACE) begin
                expTrace_r <= pwdata[7:0];
            end else if (paddr == `OFS_DEG_CFG) begin
                degrade_threshold_r <= pwdata[15:0];
                degWin_r <= pwdata[19:16];
            end
        end
    end

    // ==========================================================
    // Overhead extraction
    logic [7:0] bipAcc_r;
    logic [7:0] bipPrev_r;
    logic       bipValid_r;
    logic       bipStart_r;
    logic       nearBlock_r;
    logic       farBlock_r;
    logic [7:0] traceCand_r;
    persist_t   traceSt_r;
    logic       traceSeen_r;
    persist_t   ais_r;
    persist_t   uneq_r;
    persist_t   rdi_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            bipAcc_r   <= 8'h00;
            bipPrev_r  <= 8'h00;
            bipValid_r <= 1'b0;
            bipStart_r <= 1'b0;
        end else if (pathEdge) begin
            if (syncB_r.fs) begin
                bipPrev_r  <= bipAcc_r;
                bipAcc_r   <= syncB_r.data;
                // First frame after reset is partial, its sum is not checked
                bipValid_r <= bipStart_r;
                bipStart_r <= 1'b1;
            end else begin
                bipAcc_r <= bipAcc_r ^ syncB_r.data;
            end
        end
    end

    // one block per frame on mismatch
    always_ff @(posedge mclk) begin
        if (srst) begin
            nearBlock_r <= 1'b0;
        end else begin
            nearBlock_r <= pathEdge & bipValid_r & (curIdx == `POS_PARITY) &
                           (syncB_r.data != bipPrev_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            farBlock_r <= 1'b0;
        end else begin
            farBlock_r <= pathEdge & (curIdx == `POS_STATUS) &
                          (syncB_r.data[7:4] != 4'h0) & (syncB_r.data[7:4] <= `REI_MAX);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            traceCand_r <= 8'h00;
            traceSt_r   <= '0;
            traceSeen_r <= 1'b0;
        end else if (pathEdge && syncB_r.fs) begin
            traceCand_r <= syncB_r.data;
            if (syncB_r.data == traceCand_r) begin
                traceSt_r <= persistStep(traceSt_r, ~traceSt_r.defect, `TRACE_FRAMES);
            end else begin
                traceSt_r <= '0;
            end
        end else if (traceSt_r.defect) begin
            traceSt_r   <= '0;
            traceSeen_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            acceptedTraceId <= 8'h00;
        end else if (traceSt_r.defect) begin
            acceptedTraceId <= traceCand_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ais_r  <= '0;
            uneq_r <= '0;
        end else if (pathEdge && curIdx == `POS_LABEL) begin
            ais_r  <= persistStep(ais_r, syncB_r.data == `LABEL_AIS, `PERSIST_FRAMES);
            uneq_r <= persistStep(uneq_r, syncB_r.data == `LABEL_UNEQ, `PERSIST_FRAMES);
        end
    end

    // remote defect from status bit five
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdi_r <= '0;
        end else if (pathEdge && curIdx == `POS_STATUS) begin
            rdi_r <= persistStep(rdi_r, syncB_r.data[`RDI_BIT], `PERSIST_FRAMES);
        end
    end

    // ==========================================================
    // Defects, actions and causes
    logic uneqEff;
    logic timEff;
    logic rdiEff;
    logic degEff;
    logic degRaw_r;

    // suppression by server fail or AIS
    assign suppress = syncB_r.ssf | ais_r.defect;
    assign uneqEff  = uneq_r.defect & ~suppress;
    assign timEff   = traceSeen_r & (acceptedTraceId != expTrace_r) &
                      ~ctrl_r[`CTRL_TRACE_MISMATCH_DISABLE_BIT] & ~suppress;
    assign rdiEff   = rdi_r.defect & ~suppress;
    assign degEff   = degRaw_r & ~suppress;

    always_ff @(posedge mclk) begin
        if (srst) begin
            trailFailAction     <= 1'b0;
            trailDegradedAction <= 1'b0;
        end else begin
            trailFailAction     <= suppress | uneqEff | timEff;
            trailDegradedAction <= degEff;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            faultCause <= '0;
        end else begin
            faultCause.uneq <= uneqEff & monitored;
            faultCause.tim  <= timEff & ~uneqEff & monitored;
            faultCause.deg  <= degEff & ~timEff & monitored;
            faultCause.rdi  <= rdiEff & ~uneqEff & ~timEff & monitored &
                               ctrl_r[`CTRL_RDIREP_BIT];
            faultCause.ssf  <= suppress & monitored & ctrl_r[`CTRL_SSFREP_BIT];
        end
    end

    // ==========================================================
    // One-second performance monitoring
    logic [CNT_W-1:0] nearAcc_r;
    logic [CNT_W-1:0] farAcc_r;
    logic             nearDs_r;
    logic             farDs_r;
    logic [3:0]       badRun_r;
    logic [3:0]       goodRun_r;
    logic             badSecond;

    always_ff @(posedge mclk) begin
        if (srst) begin
            nearAcc_r           <= '0;
            farAcc_r            <= '0;
            nearBlockErrorCount <= '0;
            farBlockErrorCount  <= '0;
            perfValid           <= 1'b0;
        end else if (oneSecond) begin
            nearBlockErrorCount <= nearAcc_r;
            farBlockErrorCount  <= farAcc_r;
            nearAcc_r           <= {{(CNT_W-1){1'b0}}, nearBlock_r};
            farAcc_r            <= {{(CNT_W-1){1'b0}}, farBlock_r};
            perfValid           <= 1'b1;
        end else begin
            nearAcc_r <= satAdd(nearAcc_r, nearBlock_r);
            farAcc_r  <= satAdd(farAcc_r, farBlock_r);
            perfValid <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            nearDs_r         <= 1'b0;
            farDs_r          <= 1'b0;
            nearDefectSecond <= 1'b0;
            farDefectSecond  <= 1'b0;
        end else if (oneSecond) begin
            nearDefectSecond <= nearDs_r | trailFailAction | syncB_r.eq;
            farDefectSecond  <= farDs_r | rdiEff;
            nearDs_r         <= 1'b0;
            farDs_r          <= 1'b0;
        end else begin
            nearDs_r <= nearDs_r | trailFailAction | syncB_r.eq;
            farDs_r  <= farDs_r | rdiEff;
        end
    end

    // Degrade over consecutive bad seconds
    assign badSecond = (nearAcc_r >= CNT_W'(degrade_threshold_r)) && (degrade_threshold_r != 16'h0000);

    always_ff @(posedge mclk) begin
        if (srst) begin
            badRun_r  <= 4'h0;
            goodRun_r <= 4'h0;
            degRaw_r  <= 1'b0;
        end else if (oneSecond) begin
            badRun_r  <= badSecond ? badRun_r + 4'h1 : 4'h0;
            goodRun_r <= badSecond ? 4'h0 : goodRun_r + 4'h1;
            if (badSecond && badRun_r + 4'h1 >= degWin_r) begin
                degRaw_r <= 1'b1;
            end else if (!badSecond && goodRun_r + 4'h1 >= degWin_r) begin
                degRaw_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // APB slave, one wait state
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & (paddr > `OFS_SECOND || paddr[1:0] != 2'h0);
            if (paddr == `OFS_CTRL) begin
                prdata <= {28'h0, ctrl_r};
            end else if (paddr == `OFS_EXP_TRACE) begin
                prdata <= {24'h0, expTrace_r};
            end else if (paddr == `OFS_DEG_CFG) begin
                prdata <= {12'h0, degWin_r, degrade_threshold_r};
            end else if (paddr == `OFS_STATUS) begin
                prdata <= {19'h0, faultCause, trailDegradedAction, trailFailAction,
                           syncB_r.ssf, ais_r.defect, uneq_r.defect, timEff, rdi_r.defect,
                           degRaw_r};
            end else if (paddr == `OFS_ACC_TRACE) begin
                prdata <= {24'h0, acceptedTraceId};
            end else if (paddr == `OFS_NEAR_COUNT) begin
                prdata <= 32'(nearBlockErrorCount);
            end else if (paddr == `OFS_FAR_COUNT) begin
                prdata <= 32'(farBlockErrorCount);
            end else if (paddr == `OFS_SECOND) begin
                prdata <= {30'h0, farDefectSecond, nearDefectSecond};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Checks
    fail_sources_a: assert property (@(posedge mclk) disable iff (srst)
        (syncB_r.ssf | ais_r.defect | uneqEff | timEff) |=> trailFailAction)
        else $error("trail fail missing");

    degrade_follow_a: assert property (@(posedge mclk) disable iff (srst)
        trailDegradedAction == $past(degEff))
        else $error("degraded action mismatch");

    uneq_cause_a: assert property (@(posedge mclk) disable iff (srst)
        faultCause.uneq |-> $past(uneqEff) && $past(monitored))
        else $error("unequipped cause unjustified");

    tim_cause_a: assert property (@(posedge mclk) disable iff (srst)
        faultCause.tim |-> !faultCause.uneq)
        else $error("mismatch cause with unequipped");

    rdi_cause_a: assert property (@(posedge mclk) disable iff (srst)
        faultCause.rdi |-> $past(ctrl_r[`CTRL_RDIREP_BIT]) && !faultCause.tim)
        else $error("remote cause unjustified");

    ssf_cause_a: assert property (@(posedge mclk) disable iff (srst)
        (monitored && ctrl_r[`CTRL_SSFREP_BIT] && ais_r.defect && $stable(ctrl_r))
        |=> faultCause.ssf)
        else $error("server cause missing");

    ais_label_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(ais_r.defect) |-> $past(syncB_r.data) == `LABEL_AIS)
        else $error("AIS raised on wrong label");

    ais_clear_a: assert property (@(posedge mclk) disable iff (srst)
        $fell(ais_r.defect) |-> $past(syncB_r.data) != `LABEL_AIS)
        else $error("AIS cleared on all-ones label");

    tim_disable_a: assert property (@(posedge mclk) disable iff (srst)
        ctrl_r[`CTRL_TRACE_MISMATCH_DISABLE_BIT] |-> !timEff)
        else $error("mismatch while disabled");

    suppress_a: assert property (@(posedge mclk) disable iff (srst)
        suppress |=> !faultCause.deg && !faultCause.uneq)
        else $error("defect not suppressed");

    tick_latch_a: assert property (@(posedge mclk) disable iff (srst)
        oneSecond |=> perfValid && nearBlockErrorCount == $past(nearAcc_r))
        else $error("near count not latched");

    near_block_a: assert property (@(posedge mclk) disable iff (srst)
        nearBlock_r |-> $past(curIdx) == `POS_PARITY)
        else $error("near block outside parity byte");

endmodule

`default_nettype wire

// >>> verification/vc3_path_source.sv
/*
 * Upstream path source: back-to-back frames of 765 bytes carrying the
 * trace, parity, label and status bytes at their fixed positions.
 * Assumes a free-running 200 ns byte clock; bytes change on its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module vc3_path_source #(
    parameter logic [7:0] TRACE = 8'h5a
) (
    input  wire logic [7:0] label,
    input  wire logic [7:0] status,
    input  wire logic [7:0] parityFlip,
    output logic            pathClk,
    output logic [7:0]      pathData,
    output logic            pathFrameStart
);
    // ====================
    // Byte clock
    initial begin
        pathClk = 1'b0;
        forever #100 pathClk = ~pathClk;
    end

    // ====================
    // Frame builder, parity carried into the next frame
    int         idx = 0;
    logic [7:0] bip = 8'h00;
    logic [7:0] sum = 8'h00;
    logic [7:0] b;
    initial begin
        pathData = 8'h00;
        pathFrameStart = 1'b0;
    end
    always @(negedge pathClk) begin
        case (idx)
            0: b = TRACE;
            85: b = bip ^ parityFlip;
            170: b = label;
            255: b = status;
            default: b = idx[7:0] ^ 8'h3c;
        endcase
        pathData <= b;
        pathFrameStart <= (idx == 0);
        sum = sum ^ b;
        if (idx == 764) begin
            bip = sum;
            sum = 8'h00;
            idx = 0;
        end else begin
            idx = idx + 1;
        end
    end
endmodule

`default_nettype wire

// >>> verification/vc3_path_nonintrusive_monitor_test.sv
/*
 * Self-checking bench of the VC-3 path monitor: APB register access,
 * server fail correlation, block counts, remote defect and AIS filters.
 * Assumes the package and vc3_mon_cfg.svh are compiled first.
 */
`timescale 1ns/1ps
`include "vc3_mon_cfg.svh"
`default_nettype none

module vc3_path_nonintrusive_monitor_test;
    import vc3_mon_pkg::*;
    localparam logic [7:0] TRACE = 8'h5a;
    logic        mclk, srst, oneSecond, ssf, eqDef, psel, penable, pwrite;
    logic [7:0]  paddr, label, status, flip, pathData, accTrace;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, pathClk, fs, tsf, tsd, nds, fds, perfValid;
    logic [15:0] nearCnt, farCnt;
    cause_t      cause;
    int          nMismatch = 0;
    int          nTests = 0;

    // ====================
    // Design and upstream source
    vc3_path_monitor i_vc3_path_monitor (
        .mclk(mclk), .srst(srst), .pathClk(pathClk), .pathData(pathData),
        .pathFrameStart(fs), .incomingServerFail(ssf), .equipmentDefectIn(eqDef),
        .oneSecond(oneSecond), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trailFailAction(tsf), .trailDegradedAction(tsd),
        .faultCause(cause), .acceptedTraceId(accTrace), .nearBlockErrorCount(nearCnt),
        .farBlockErrorCount(farCnt), .nearDefectSecond(nds), .farDefectSecond(fds),
        .perfValid(perfValid)
    );
    vc3_path_source #(.TRACE(TRACE)) i_vc3_path_source (
        .label(label), .status(status), .parityFlip(flip),
        .pathClk(pathClk), .pathData(pathData), .pathFrameStart(fs)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ====================
    // Tasks
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", nMismatch, nTests);
        if (nMismatch == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            nMismatch++;
            end_of_test();
        end
        check(32'(pslverr), 32'(err));
        if (!wr) begin
            check(prdata, d);
        end
    endtask

    task automatic frames(input int k);
        int n;
        repeat (k) begin
            n = 0;
            while (fs === 1'b1 && n < 9000) begin
                @(posedge mclk);
                n++;
            end
            while (fs !== 1'b1 && n < 9000) begin
                @(posedge mclk);
                n++;
            end
            if (n >= 9000) begin
                nMismatch++;
                end_of_test();
            end
        end
    endtask

    task automatic tick();
        @(posedge mclk);
        oneSecond <= 1'b1;
        @(posedge mclk);
        oneSecond <= 1'b0;
        #1;
        check(32'(perfValid), 32'h1);
    endtask

    // ====================
    // Main sequence
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, oneSecond, ssf, eqDef} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        label = 8'h01;
        status = 8'h00;
        flip = 8'h00;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        bus(1'b0, `OFS_CTRL, {28'h0, `CTRL_RESET}, 1'b0);
        bus(1'b0, `OFS_DEG_CFG, {12'h0, `DEG_WIN_RESET, `DEG_THR_RESET}, 1'b0);
        bus(1'b0, `OFS_EXP_TRACE, {24'h0, `EXP_TRACE_RESET}, 1'b0);
        bus(1'b0, 8'h20, 32'h0, 1'b1);
        bus(1'b1, 8'h20, 32'hffff_ffff, 1'b1);
        bus(1'b1, `OFS_EXP_TRACE, {24'h0, TRACE}, 1'b0);
        bus(1'b1, `OFS_CTRL, 32'h5, 1'b0);
        ssf <= 1'b1;
        repeat (6) @(posedge mclk);
        check(32'(tsf), 32'h1);
        check(32'(cause), 32'h0);
        bus(1'b1, `OFS_CTRL, 32'h3, 1'b0);
        repeat (3) @(posedge mclk);
        check(32'(cause), 32'h01);
        bus(1'b1, `OFS_CTRL, 32'h2, 1'b0);
        repeat (3) @(posedge mclk);
        check(32'(cause), 32'h0);
        ssf <= 1'b0;
        bus(1'b1, `OFS_CTRL, 32'h5, 1'b0);
        // Far code 1000 with remote defect, every parity byte wrong
        status <= 8'h88;
        flip <= 8'h01;
        frames(1);
        tick();
        eqDef <= 1'b1;
        frames(3);
        eqDef <= 1'b0;
        repeat (4) @(posedge mclk);
        tick();
        check(32'(nearCnt), 32'd3);
        check(32'(farCnt), 32'd3);
        check(32'(fds), 32'h0);
        check(32'(nds), 32'h1);
        frames(2);
        check(32'(cause), 32'h02);
        check(32'(accTrace), 32'(TRACE));
        tick();
        check(32'(nearCnt), 32'd2);
        check(32'(farCnt), 32'd2);
        check(32'(fds), 32'h1);
        check(32'(nds), 32'h0);
        // Second bad second in a row sets degrade
        repeat (2) @(posedge mclk);
        check(32'(tsd), 32'h1);
        check(32'(cause), 32'h06);
        // Trace mismatch, then mismatch detection off
        bus(1'b1, `OFS_EXP_TRACE, 32'ha5, 1'b0);
        repeat (3) @(posedge mclk);
        check(32'(tsf), 32'h1);
        check(32'(cause), 32'h08);
        bus(1'b1, `OFS_CTRL, 32'hd, 1'b0);
        repeat (3) @(posedge mclk);
        check(32'(tsf), 32'h0);
        check(32'(cause), 32'h06);
        bus(1'b1, `OFS_EXP_TRACE, {24'h0, TRACE}, 1'b0);
        // All-ones label, far code 1001, status low bits set
        label <= `LABEL_AIS;
        status <= 8'h97;
        flip <= 8'h00;
        bus(1'b1, `OFS_CTRL, 32'h7, 1'b0);
        frames(4);
        check(32'(tsf), 32'h0);
        frames(1);
        check(32'(tsf), 32'h1);
        check(32'(cause), 32'h01);
        tick();
        check(32'(nearCnt), 32'd0);
        check(32'(farCnt), 32'd0);
        check(32'(nds), 32'h1);
        // All-zero label clears AIS and raises unequipped
        label <= `LABEL_UNEQ;
        frames(4);
        check(32'(tsf), 32'h1);
        frames(1);
        check(32'(tsf), 32'h1);
        check(32'(cause), 32'h14);
        bus(1'b0, `OFS_STATUS, 32'h0000_14c9, 1'b0);
        end_of_test();
    end
endmodule

`default_nettype wire
